//--- sctc_defs.vh
`ifndef SCTC_DEFS_VH
`define SCTC_DEFS_VH
// Subblocks per block
`define SCTC_NSUB 4
`define SCTC_SUB_W 2
// Command codes
`define SCTC_OP_READ 2'h0
`define SCTC_OP_WRITE 2'h1
`define SCTC_OP_CLEAN 2'h2
`define SCTC_OP_FLUSH 2'h3
// Default geometry
`define SCTC_ADDR_W 16
`define SCTC_DATA_W 32
`define SCTC_NBLK 4
`define SCTC_BLK_IDX_W 2
`define SCTC_WORDS_W 2
`endif

//--- sctc_lru.v
`timescale 1ns/1ps
`default_nettype none
// Age-matrix least-recently-used tracker for a fully associative block set
module sctc_lru #(
	parameter NBLK = 4,
	parameter IDX_W = 2
) (
	input wire mclk_i,
	input wire resetn_i,
	input wire touch_i,
	input wire [IDX_W-1:0] touch_idx_i,
	output reg [IDX_W-1:0] victim_o
);
	reg [NBLK-1:0] older [0:NBLK-1];
	integer i;
	integer j;
	// Row i bit j set: block i used before block j
	always @(posedge mclk_i) begin
		if (!resetn_i) begin
			// Seed a full order, highest index oldest, so a victim exists from the start
			for (i = 0; i < NBLK; i = i + 1)
				older[i] <= {NBLK{1'b1}} >> (NBLK - i);
		end else if (touch_i) begin
			for (i = 0; i < NBLK; i = i + 1) begin
				if (i == touch_idx_i)
					older[i] <= {NBLK{1'b0}};
				else
					older[i][touch_idx_i] <= 1'b1;
			end
		end
	end
	// Victim is the block older than all others; ties fall to highest index
	always @* begin
		victim_o = {IDX_W{1'b0}};
		for (j = 0; j < NBLK; j = j + 1)
			if ((older[j] | ({{(NBLK-1){1'b0}}, 1'b1} << j)) == {NBLK{1'b1}})
				victim_o = j[IDX_W-1:0];
	end
endmodule // sctc_lru
`default_nettype wire

//--- sctc_cache.v
`timescale 1ns/1ps
`default_nettype none
`include "sctc_defs.vh"
module sctc_cache #(
	parameter ADDR_W = `SCTC_ADDR_W,
	parameter DATA_W = `SCTC_DATA_W,
	parameter NBLK = `SCTC_NBLK,
	parameter IDX_W = `SCTC_BLK_IDX_W,
	parameter WORDS_W = `SCTC_WORDS_W,
	parameter DATA_CACHE = 1
) (
	input wire mclk_i,
	input wire resetn_i,
	// Core side
	input wire req_i,
	input wire [1:0] op_i,
	input wire [ADDR_W-1:0] addr_i,
	input wire [DATA_W-1:0] wdata_i,
	output reg ack_o,
	output reg hit_o,
	output reg miss_o,
	output reg [DATA_W-1:0] rdata_o,
	// External memory side, one subblock per burst
	output reg mem_req_o,
	output reg mem_we_o,
	output reg [ADDR_W-1:0] mem_addr_o,
	output reg [DATA_W-1:0] mem_wdata_o,
	input wire mem_ack_i,
	input wire [DATA_W-1:0] mem_rdata_i
);
	localparam NSUB = `SCTC_NSUB;
	localparam SUB_W = `SCTC_SUB_W;
	localparam NW = 1 << WORDS_W;
	localparam TAG_W = ADDR_W - SUB_W - WORDS_W;
	localparam DW = IDX_W + SUB_W + WORDS_W;
	localparam S_IDLE = 6'h01;
	localparam S_LOOK = 6'h02;
	localparam S_WB = 6'h04;
	localparam S_FILL = 6'h08;
	localparam S_MAINT = 6'h10;
	localparam S_DONE = 6'h20;
	// Tag, present and dirty storage per block
	reg [TAG_W-1:0] tag [0:NBLK-1];
	reg [NSUB-1:0] present [0:NBLK-1];
	reg [NSUB-1:0] dirty [0:NBLK-1];
	reg [DATA_W-1:0] mem [0:NBLK*NSUB*NW-1];
	reg [5:0] state;
	reg [1:0] op;
	reg [ADDR_W-1:0] addr;
	reg [DATA_W-1:0] wdata;
	reg [IDX_W-1:0] blk;
	reg [SUB_W-1:0] sub;
	reg [WORDS_W-1:0] word;
	reg wb_then_fill;
	reg was_hit;
	reg touch;
	wire [IDX_W-1:0] victim;
	reg blk_hit;
	reg [IDX_W-1:0] hit_idx;
	integer k;
	integer r;
	wire [TAG_W-1:0] a_tag = addr[ADDR_W-1:SUB_W+WORDS_W];
	wire [SUB_W-1:0] a_sub = addr[SUB_W+WORDS_W-1:WORDS_W];
	wire [WORDS_W-1:0] a_word = addr[WORDS_W-1:0];
	// Storage index from block, subblock and word
	function [DW-1:0] widx;
		input [IDX_W-1:0] b;
		input [SUB_W-1:0] s;
		input [WORDS_W-1:0] w;
		widx = {b, s, w};
	endfunction
	// Find first dirty subblock of a mask
	function [SUB_W:0] first_dirty;
		input [NSUB-1:0] m;
		integer n;
		begin
			first_dirty = {1'b1, {SUB_W{1'b0}}};
			for (n = NSUB - 1; n >= 0; n = n - 1)
				if (m[n])
					first_dirty = {1'b0, n[SUB_W-1:0]};
		end
	endfunction
	// Associative tag compare
	always @* begin
		blk_hit = 1'b0;
		hit_idx = {IDX_W{1'b0}};
		for (k = 0; k < NBLK; k = k + 1)
			if (present[k] != {NSUB{1'b0}} && tag[k] == a_tag) begin
				blk_hit = 1'b1;
				hit_idx = k[IDX_W-1:0];
			end
	end
	sctc_lru #(.NBLK(NBLK), .IDX_W(IDX_W)) u_lru (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.touch_i(touch),
		.touch_idx_i(blk),
		.victim_o(victim)
	);
	wire [SUB_W:0] fd = first_dirty(dirty[blk]);
	// Main sequencer; memory port owned here so hits never reach it
	always @(posedge mclk_i) begin
		if (!resetn_i) begin
			state <= S_IDLE;
			for (r = 0; r < NBLK; r = r + 1) begin
				present[r] <= {NSUB{1'b0}};
				dirty[r] <= {NSUB{1'b0}};
				tag[r] <= {TAG_W{1'b0}};
			end
			op <= 2'h0;
			addr <= {ADDR_W{1'b0}};
			wdata <= {DATA_W{1'b0}};
			blk <= {IDX_W{1'b0}};
			sub <= {SUB_W{1'b0}};
			word <= {WORDS_W{1'b0}};
			wb_then_fill <= 1'b0;
			was_hit <= 1'b0;
			touch <= 1'b0;
			ack_o <= 1'b0;
			hit_o <= 1'b0;
			miss_o <= 1'b0;
			rdata_o <= {DATA_W{1'b0}};
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= {ADDR_W{1'b0}};
			mem_wdata_o <= {DATA_W{1'b0}};
		end else begin
			ack_o <= 1'b0;
			touch <= 1'b0;
			case (state)
			S_IDLE: begin
				hit_o <= 1'b0;
				miss_o <= 1'b0;
				if (req_i) begin
					op <= op_i;
					addr <= addr_i;
					wdata <= wdata_i;
					blk <= {IDX_W{1'b0}};
					state <= (op_i[1]) ? S_MAINT : S_LOOK;
				end
			end
			S_LOOK: begin
				if (blk_hit && present[hit_idx][a_sub]) begin
					// Served locally, no external cycle
					blk <= hit_idx;
					was_hit <= 1'b1;
					state <= S_DONE;
				end else if (blk_hit) begin
					// Subblock miss: fetch just this subblock
					blk <= hit_idx;
					was_hit <= 1'b0;
					sub <= a_sub;
					word <= {WORDS_W{1'b0}};
					state <= S_FILL;
				end else begin
					// Block miss: reallocate the LRU block
					blk <= victim;
					was_hit <= 1'b0;
					wb_then_fill <= 1'b1;
					word <= {WORDS_W{1'b0}};
					state <= S_WB;
				end
			end
			S_WB: begin
				// Write back the victim's or walked block's dirty subblocks one at a time
				if (!fd[SUB_W] && DATA_CACHE != 0) begin
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b1;
					mem_addr_o <= {tag[blk], fd[SUB_W-1:0], word};
					mem_wdata_o <= mem[widx(blk, fd[SUB_W-1:0], word)];
					if (mem_req_o && mem_ack_i) begin
						mem_req_o <= 1'b0;
						word <= word + 1'b1;
						if (word == NW - 1) begin
							dirty[blk][fd[SUB_W-1:0]] <= 1'b0;
							if (op == `SCTC_OP_FLUSH)
								present[blk][fd[SUB_W-1:0]] <= 1'b0;
						end
					end
				end else if (wb_then_fill) begin
					// Whole block reallocated: drop old subblocks
					tag[blk] <= a_tag;
					present[blk] <= {NSUB{1'b0}};
					dirty[blk] <= {NSUB{1'b0}};
					wb_then_fill <= 1'b0;
					sub <= a_sub;
					word <= {WORDS_W{1'b0}};
					state <= S_FILL;
				end else begin
					if (op == `SCTC_OP_FLUSH)
						present[blk] <= {NSUB{1'b0}};
					state <= S_MAINT;
					blk <= blk + 1'b1;
					if (blk == NBLK - 1)
						state <= S_DONE;
				end
			end
			S_FILL: begin
				mem_req_o <= 1'b1;
				mem_we_o <= 1'b0;
				mem_addr_o <= {a_tag, sub, word};
				if (mem_req_o && mem_ack_i) begin
					mem_req_o <= 1'b0;
					mem[widx(blk, sub, word)] <= mem_rdata_i;
					word <= word + 1'b1;
					if (word == NW - 1) begin
						present[blk][sub] <= 1'b1;
						state <= S_DONE;
					end
				end
			end
			S_MAINT: begin
				// Walk every block for clean or flush
				word <= {WORDS_W{1'b0}};
				state <= S_WB;
			end
			S_DONE: begin
				if (!op[1]) begin
					rdata_o <= mem[widx(blk, a_sub, a_word)];
					touch <= 1'b1;
					if (op == `SCTC_OP_WRITE) begin
						mem[widx(blk, a_sub, a_word)] <= wdata;
						if (DATA_CACHE != 0)
							dirty[blk][a_sub] <= 1'b1;
					end
				end
				hit_o <= was_hit & ~op[1];
				miss_o <= ~was_hit & ~op[1];
				ack_o <= 1'b1;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // sctc_cache
`default_nettype wire

//--- sctc_cache_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sctc_cache_sva #(parameter ADDR_W = 16) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic ack_o,
	input wire logic hit_o,
	input wire logic miss_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic mem_ack_i
);
	logic [3:0] nf, nw;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// Words moved since last completion; wrap is fine, only whole subblocks matter
	always @(posedge mclk_i) begin
		if (!resetn_i || ack_o) begin
			nf <= 4'h0;
			nw <= 4'h0;
		end else if (mem_req_o && mem_ack_i) begin
			nf <= nf + {3'h0, !mem_we_o};
			nw <= nw + {3'h0, mem_we_o};
		end
	end
	a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack width");
	a_hit_miss_excl: assert property (ack_o |-> !(hit_o && miss_o)) else $error("hit and miss");
	a_hit_no_mem: assert property (ack_o && hit_o |->
		!mem_req_o && nf == 4'h0 && nw == 4'h0) else $error("memory used on hit");
	a_miss_one_sub: assert property (ack_o && miss_o |-> nf == 4'h4) else $error("fill size");
	a_wb_whole_sub: assert property (ack_o |-> nw[1:0] == 2'h0) else $error("partial writeback");
	a_wb_before_fill: assert property (mem_req_o && !mem_we_o |-> nw[1:0] == 2'h0)
		else $error("fill inside writeback");
	a_mem_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
		&& $stable(mem_addr_o) && $stable(mem_we_o)) else $error("memory request moved");
	a_mem_req_drop: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("memory request kept");
endmodule // sctc_cache_sva
bind sctc_cache sctc_cache_sva #(.ADDR_W(ADDR_W)) i_sctc_cache_sva (.mclk_i, .resetn_i, .ack_o,
	.hit_o, .miss_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i);
`default_nettype wire

//--- sctc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sctc_mem_model (
	input wire logic mclk_i,
	input wire logic slow_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [31:0] wdata_i,
	output logic ack_o = 1'h0,
	output logic [31:0] rdata_o = 32'h0
);
	logic [31:0] mem [0:65535];
	logic [1:0] wait_n = 2'h0;
	initial for (int i = 0; i < 65536; i++) mem[i] = {16'ha5a5, i[15:0]};
	// One word a handshake; data line toggles outside read answer cycles
	always @(posedge mclk_i) begin
		ack_o <= 1'h0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o && wait_n >= {slow_i, slow_i}) begin
			ack_o <= 1'h1;
			wait_n <= 2'h0;
			if (we_i) mem[addr_i] <= wdata_i;
			else rdata_o <= mem[addr_i];
		end else if (req_i) wait_n <= wait_n + 2'h1;
	end
endmodule // sctc_mem_model
`default_nettype wire

//--- tb_sctc_cache.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sctc_cache;
	logic mclk_i = 0, resetn_i = 0, req_i = 0, slow = 0, mem_ack_i;
	logic [1:0] op_i = 0;
	logic [15:0] addr_i = 0, mem_addr_o;
	logic [31:0] wdata_i = 0, rdata_o, mem_wdata_o, mem_rdata_i;
	logic ack_o, hit_o, miss_o, mem_req_o, mem_we_o;
	int err_total = 0, total_checks = 0;
	always #10 mclk_i = ~mclk_i;
	sctc_cache i_sctc_cache (.mclk_i, .resetn_i, .req_i, .op_i, .addr_i, .wdata_i, .ack_o, .hit_o,
		.miss_o, .rdata_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i);
	sctc_mem_model i_mem (.mclk_i(mclk_i), .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
	function automatic logic [31:0] pat(logic [15:0] a);
		return {16'ha5a5, a};
	endfunction
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One request, held for the taking edge, then wait for the completion pulse
	task automatic run(logic [1:0] o, logic [15:0] a, logic [31:0] d, logic h, logic m);
		int n;
		@(negedge mclk_i);
		op_i = o;
		addr_i = a;
		wdata_i = d;
		req_i = 1;
		@(negedge mclk_i);
		req_i = 0;
		for (n = 0; n < 400 && ack_o !== 1'h1; n++) @(negedge mclk_i);
		chk("ack", ack_o, 1'h1);
		chk("hit", hit_o, h);
		chk("miss", miss_o, m);
	endtask
	task automatic rd(logic [15:0] a, logic [31:0] e, logic h, logic m);
		run(2'h0, a, 32'h0, h, m);
		chk("rdata", rdata_o, e);
	endtask
	task t_fill;
		rd(16'h0010, pat(16'h0010), 0, 1);
		rd(16'h0013, pat(16'h0013), 1, 0);
		rd(16'h0014, pat(16'h0014), 0, 1);
	endtask
	task t_clean;
		run(2'h1, 16'h0011, 32'h1111, 1, 0);
		run(2'h2, 16'h0, 32'h0, 0, 0);
		chk("clean wb", i_mem.mem[17], 32'h1111);
		rd(16'h0011, 32'h1111, 1, 0);
	endtask
	task t_flush;
		run(2'h1, 16'h0011, 32'h2222, 1, 0);
		run(2'h3, 16'h0, 32'h0, 0, 0);
		chk("flush wb", i_mem.mem[17], 32'h2222);
		rd(16'h0011, 32'h2222, 0, 1);
	endtask
	// Slow memory; dirty block made least recent, then displaced
	task t_lru;
		slow = 1;
		run(2'h3, 16'h0, 32'h0, 0, 0);
		rd(16'h0020, pat(16'h0020), 0, 1);
		run(2'h1, 16'h0030, 32'h3333, 0, 1);
		rd(16'h0040, pat(16'h0040), 0, 1);
		rd(16'h0050, pat(16'h0050), 0, 1);
		rd(16'h0020, pat(16'h0020), 1, 0);
		rd(16'h0060, pat(16'h0060), 0, 1);
		chk("victim wb", i_mem.mem[48], 32'h3333);
		rd(16'h0040, pat(16'h0040), 1, 0);
		rd(16'h0030, 32'h3333, 0, 1);
	endtask
	initial begin
		repeat (6) @(negedge mclk_i);
		resetn_i = 1;
		chk("reset", {ack_o, mem_req_o}, 32'h0);
		t_fill;
		t_clean;
		t_flush;
		t_lru;
		give_verdict;
	end
	// Hang guard, far beyond the expected few hundred cycles
	initial begin
		#200us;
		err_total++;
		give_verdict;
	end
endmodule // tb_sctc_cache
`default_nettype wire
